/* design/aseu_pkg.sv */
// Shared constants, types and arithmetic helpers of the add and shift execute unit
package aseu_pkg;

    typedef enum logic [2:0] {
        SH_LSL,
        SH_LSR,
        SH_ASR,
        SH_ROR,
        SH_ROTATE_EXTEND
    } aseu_shift_t;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD_CARRY,
        OP_ADD_IMM_THREE_FIELD,
        OP_ADD_IMM_EIGHT_FIELD,
        OP_ADD_REG3,
        OP_ADD_REG4,
        OP_SP_IMM_EIGHT_FIELD,
        OP_SP_IMM_SEVEN_FIELD,
        OP_HINT,
        OP_WIDE
    } aseu_op_t;

    typedef struct packed {
        logic [31:0] result;
        logic        carry;
        logic        overflow;
    } aseu_sum_t;

    // Opcode patterns of the short encodings
    localparam logic [9:0] OPC_ADD_CARRY = 10'h105;
    localparam logic [6:0] OPC_ADD_IMM_THREE_FIELD  = 7'h0E;
    localparam logic [4:0] OPC_ADD_IMM_EIGHT_FIELD  = 5'h06;
    localparam logic [6:0] OPC_ADD_REG3  = 7'h0C;
    localparam logic [7:0] OPC_ADD_REG4  = 8'h44;
    localparam logic [4:0] OPC_SP_IMM_EIGHT_FIELD   = 5'h15;
    localparam logic [8:0] OPC_SP_IMM_SEVEN_FIELD   = 9'h160;
    localparam logic [7:0] OPC_HINT      = 8'hBF;
    localparam logic [3:0] HINT_LOW      = 4'h0;
    localparam logic [2:0] WIDE_TOP      = 3'h7;
    localparam logic [1:0] WIDE_NOT      = 2'h0;

    localparam logic [3:0] REG_SP = 4'hD;
    localparam logic [3:0] REG_PC = 4'hF;

    // Flag positions inside the four-bit flag register
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_C = 1;
    localparam int unsigned FLAG_V = 0;
    localparam logic [3:0]  FLAGS_RESET = 4'h0;
    localparam int unsigned FLAGS_LSB   = 28;
    localparam logic [31:0] GPR_RESET   = 32'h0;

    // Register port map
    localparam logic [4:0] ADDR_GPR_LAST = 5'h0F;
    localparam logic [4:0] ADDR_FLAGS    = 5'h10;
    localparam logic [4:0] ADDR_EVENTS   = 5'h11;

    // Sticky event bits
    localparam int unsigned EVT_UNDEF     = 0;
    localparam int unsigned EVT_SP_REG    = 1;
    localparam int unsigned EVT_UNPRED    = 2;
    localparam int unsigned EVT_PC_WRITE  = 3;
    localparam int unsigned EVT_RRX_ILLEG = 4;
    localparam logic [4:0]  EVENTS_RESET  = 5'h00;

    localparam logic [7:0] AMOUNT_NONE = 8'h00;
    localparam logic [7:0] RRX_AMOUNT  = 8'h01;

    function automatic aseu_sum_t add_carry_fn(input logic [31:0] a,
                                               input logic [31:0] b,
                                               input logic        cin);
        logic [32:0] wide;
        aseu_sum_t   s;
        wide       = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
        s.result   = wide[31:0];
        s.carry    = wide[32];
        s.overflow = (a[31] == b[31]) && (wide[31] != a[31]);
        return s;
    endfunction

    // No conditional block instruction exists
    function automatic logic in_cond_block_fn();
        return 1'b0;
    endfunction

endpackage

/* design/aseu_shift_if.sv */
// Interface between the execute unit and its shift-with-carry unit
`timescale 1ns/100ps
interface aseu_shift_if;
    logic [31:0]        value;
    aseu_pkg::aseu_shift_t kind;
    logic [7:0]         amount;
    logic               carry_in;
    logic [31:0]        result;
    logic               carry_out;
    logic               illegal;

    modport requester (output value, kind, amount, carry_in,
                       input  result, carry_out, illegal);
    modport unit      (input  value, kind, amount, carry_in,
                       output result, carry_out, illegal);
endinterface

/* design/aseu_shifter.sv */
// Combinational shift-with-carry unit
`timescale 1ns/100ps
module aseu_shifter (
    aseu_shift_if.unit sh
);
    logic [32:0] left_w;
    logic [32:0] right_w;
    logic [32:0] arith_w;
    logic [63:0] rot_w;

    always_comb
    begin
        left_w  = {1'b0, sh.value} << sh.amount;
        right_w = {sh.value, 1'b0} >> sh.amount;
        arith_w = 33'($signed({sh.value, 1'b0}) >>> sh.amount);
        rot_w   = {sh.value, sh.value} >> sh.amount[4:0];
        sh.illegal = (sh.kind == aseu_pkg::SH_ROTATE_EXTEND)
                     && (sh.amount != aseu_pkg::RRX_AMOUNT);
        if (sh.amount == aseu_pkg::AMOUNT_NONE || sh.illegal)
        begin
            sh.result    = sh.value;
            sh.carry_out = sh.carry_in;
        end
        else
        begin
            case (sh.kind)
                aseu_pkg::SH_LSR:
                begin
                    sh.result    = right_w[32:1];
                    sh.carry_out = right_w[0];
                end
                aseu_pkg::SH_ASR:
                begin
                    sh.result    = arith_w[32:1];
                    sh.carry_out = arith_w[0];
                end
                aseu_pkg::SH_ROR:
                begin
                    sh.result    = rot_w[31:0];
                    sh.carry_out = rot_w[31];
                end
                aseu_pkg::SH_ROTATE_EXTEND:
                begin
                    sh.result    = {sh.carry_in, sh.value[31:1]};
                    sh.carry_out = sh.value[0];
                end
                default:
                begin
                    sh.result    = left_w[31:0];
                    sh.carry_out = left_w[32];
                end
            endcase
        end
    end
endmodule // aseu_shifter

/* design/aseu_exec_unit.sv */
// Add and shift execute unit with register file, flags and address generator
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// - Shift by zero returns value unchanged and passes carry in through.
// - Rotate-with-extend is legal only with shift amount one.
// - Nonzero shifts: left, right, arithmetic, rotate, rotate-extend, each with carry.
// - Offset address is base plus or minus offset; base stays unchanged.
// - No exclusive memory access operations exist.
// - Only short hint encodings decode; wide ones are undefined.
// - Add-with-carry writes first plus second plus carry into first register.
// - Flag-setting adds set N, Z, C and V from the sum.
// - Immediate adds take 3-bit or 8-bit zero-extended immediates.
// - Immediate add uses zero carry in and updates all four flags.
// - Three-register add uses low fields, zero carry in, sets flags.
// - Two-register add: 4-bit destination, no flags, stack pointer redirects.
// - Two-register add with both operands the counter is unpredictable, made safe.
// - Two-register add to the counter writes through the branch path, no flags.
// - Stack pointer plus 8-bit immediate times four into a low register.
// - Stack pointer plus 7-bit immediate times four back into stack pointer.
// - Stack pointer immediate adds never change flags.
// - Conditional block query is always false, so flag-setting adds always update flags.
module aseu_exec_unit (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic        instr_valid_in,
    input  wire logic [15:0] instr_in,
    input  wire logic        shift_req_in,
    input  wire logic [2:0]  shift_kind_in,
    input  wire logic [3:0]  shift_src_in,
    input  wire logic [7:0]  shift_amt_in,
    input  wire logic        agu_req_in,
    input  wire logic [3:0]  agu_base_in,
    input  wire logic [3:0]  agu_index_in,
    input  wire logic [7:0]  agu_imm_in,
    input  wire logic        agu_use_index_in,
    input  wire logic        agu_sub_in,
    input  wire logic [4:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [31:0]      reg_rdata_out,
    output logic             done_out,
    output logic             undef_out,
    output logic             sp_reg_redirect_out,
    output logic             unpredictable_out,
    output logic             alu_pc_write_out,
    output logic [31:0]      pc_target_out,
    output logic             shift_valid_out,
    output logic [31:0]      shift_result_out,
    output logic             shift_carry_out,
    output logic             shift_illegal_out,
    output logic             agu_valid_out,
    output logic [31:0]      agu_addr_out,
    output logic [3:0]       app_status_flags_out
);
    logic [31:0]           regs_q [16];
    logic [3:0]            flags_q;
    logic [4:0]            events_q;
    aseu_pkg::aseu_op_t    op;
    logic [3:0]            d_idx;
    logic [3:0]            n_idx;
    logic [3:0]            m_idx;
    logic [31:0]           imm32;
    logic                  use_imm;
    logic                  use_carry;
    logic                  setflags;
    logic                  redirect;
    logic                  unpred;
    logic                  is_add;
    logic                  exec_ok;
    logic                  to_pc;
    logic [31:0]           opa;
    logic [31:0]           opb;
    aseu_pkg::aseu_sum_t   sum;
    logic [31:0]           sum_res;
    logic                  instr_shift_req;
    logic [31:0]           agu_base_val;
    logic [31:0]           agu_offset;

    aseu_shift_if sh ();

    aseu_shifter u_shifter (
        .sh (sh.unit)
    );

    // Decode of the short encodings handled here
    always_comb
    begin
        op        = aseu_pkg::OP_NONE;
        d_idx     = 4'h0;
        n_idx     = 4'h0;
        m_idx     = 4'h0;
        imm32     = 32'h0000_0000;
        use_imm   = 1'b0;
        use_carry = 1'b0;
        setflags  = 1'b0;
        if (instr_in[15:6] == aseu_pkg::OPC_ADD_CARRY)
        begin
            op        = aseu_pkg::OP_ADD_CARRY;
            d_idx     = {1'b0, instr_in[2:0]};
            n_idx     = {1'b0, instr_in[2:0]};
            m_idx     = {1'b0, instr_in[5:3]};
            use_carry = 1'b1;
            setflags  = !aseu_pkg::in_cond_block_fn();
        end
        else if (instr_in[15:9] == aseu_pkg::OPC_ADD_IMM_THREE_FIELD)
        begin
            op       = aseu_pkg::OP_ADD_IMM_THREE_FIELD;
            d_idx    = {1'b0, instr_in[2:0]};
            n_idx    = {1'b0, instr_in[5:3]};
            imm32    = {29'h0000_0000, instr_in[8:6]};
            use_imm  = 1'b1;
            setflags = !aseu_pkg::in_cond_block_fn();
        end
        else if (instr_in[15:11] == aseu_pkg::OPC_ADD_IMM_EIGHT_FIELD)
        begin
            op       = aseu_pkg::OP_ADD_IMM_EIGHT_FIELD;
            d_idx    = {1'b0, instr_in[10:8]};
            n_idx    = {1'b0, instr_in[10:8]};
            imm32    = {24'h00_0000, instr_in[7:0]};
            use_imm  = 1'b1;
            setflags = !aseu_pkg::in_cond_block_fn();
        end
        else if (instr_in[15:9] == aseu_pkg::OPC_ADD_REG3)
        begin
            op       = aseu_pkg::OP_ADD_REG3;
            d_idx    = {1'b0, instr_in[2:0]};
            n_idx    = {1'b0, instr_in[5:3]};
            m_idx    = {1'b0, instr_in[8:6]};
            setflags = !aseu_pkg::in_cond_block_fn();
        end
        else if (instr_in[15:8] == aseu_pkg::OPC_ADD_REG4)
        begin
            op    = aseu_pkg::OP_ADD_REG4;
            d_idx = {instr_in[7], instr_in[2:0]};
            n_idx = {instr_in[7], instr_in[2:0]};
            m_idx = instr_in[6:3];
        end
        else if (instr_in[15:11] == aseu_pkg::OPC_SP_IMM_EIGHT_FIELD)
        begin
            op      = aseu_pkg::OP_SP_IMM_EIGHT_FIELD;
            d_idx   = {1'b0, instr_in[10:8]};
            n_idx   = aseu_pkg::REG_SP;
            imm32   = {22'h00_0000, instr_in[7:0], 2'h0};
            use_imm = 1'b1;
        end
        else if (instr_in[15:7] == aseu_pkg::OPC_SP_IMM_SEVEN_FIELD)
        begin
            op      = aseu_pkg::OP_SP_IMM_SEVEN_FIELD;
            d_idx   = aseu_pkg::REG_SP;
            n_idx   = aseu_pkg::REG_SP;
            imm32   = {23'h00_0000, instr_in[6:0], 2'h0};
            use_imm = 1'b1;
        end
        else if (instr_in[15:8] == aseu_pkg::OPC_HINT && instr_in[3:0] == aseu_pkg::HINT_LOW)
        begin
            op = aseu_pkg::OP_HINT;
        end
        else if (instr_in[15:13] == aseu_pkg::WIDE_TOP && instr_in[12:11] != aseu_pkg::WIDE_NOT)
        begin
            op = aseu_pkg::OP_WIDE;
        end
    end

    always_comb
    begin
        redirect = (op == aseu_pkg::OP_ADD_REG4)
                   && (d_idx == aseu_pkg::REG_SP || m_idx == aseu_pkg::REG_SP);
        unpred   = (op == aseu_pkg::OP_ADD_REG4) && !redirect
                   && (n_idx == aseu_pkg::REG_PC) && (m_idx == aseu_pkg::REG_PC);
        is_add   = (op != aseu_pkg::OP_NONE) && (op != aseu_pkg::OP_HINT)
                   && (op != aseu_pkg::OP_WIDE);
        exec_ok  = instr_valid_in && is_add && !redirect && !unpred;
        to_pc    = (op == aseu_pkg::OP_ADD_REG4) && (d_idx == aseu_pkg::REG_PC);
    end

    // Second operand passes the shifter unshifted; idle cycles serve shift requests
    assign instr_shift_req = instr_valid_in;
    always_comb
    begin
        if (instr_shift_req)
        begin
            sh.value  = regs_q[m_idx];
            sh.kind   = aseu_pkg::SH_LSL;
            sh.amount = aseu_pkg::AMOUNT_NONE;
        end
        else
        begin
            sh.value  = regs_q[shift_src_in];
            sh.kind   = aseu_pkg::aseu_shift_t'(shift_kind_in);
            sh.amount = shift_amt_in;
        end
        sh.carry_in = flags_q[aseu_pkg::FLAG_C];
    end

    assign opa     = regs_q[n_idx];
    assign opb     = use_imm ? imm32 : sh.result;
    assign sum     = aseu_pkg::add_carry_fn(opa, opb,
                         use_carry & flags_q[aseu_pkg::FLAG_C]);
    assign sum_res = sum.result;

    assign agu_base_val = regs_q[agu_base_in];
    assign agu_offset   = agu_use_index_in ? regs_q[agu_index_in] : {24'h00_0000, agu_imm_in};

    // Register file; execution write wins over a port write in the same cycle
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < 16; i++)
                regs_q[i] <= aseu_pkg::GPR_RESET;
        end
        else
        begin
            if (reg_wr_in && reg_addr_in <= aseu_pkg::ADDR_GPR_LAST)
                regs_q[reg_addr_in[3:0]] <= reg_wdata_in;
            if (exec_ok && !to_pc)
                regs_q[d_idx] <= sum_res;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            flags_q <= aseu_pkg::FLAGS_RESET;
        else if (exec_ok && setflags)
        begin
            flags_q[aseu_pkg::FLAG_N] <= sum_res[31];
            flags_q[aseu_pkg::FLAG_Z] <= (sum_res == 32'h0000_0000);
            flags_q[aseu_pkg::FLAG_C] <= sum.carry;
            flags_q[aseu_pkg::FLAG_V] <= sum.overflow;
        end
        else if (reg_wr_in && reg_addr_in == aseu_pkg::ADDR_FLAGS)
            flags_q <= reg_wdata_in[aseu_pkg::FLAGS_LSB +: 4];
    end

    // Sticky events: write one to clear, a new event wins over the clear
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            events_q <= aseu_pkg::EVENTS_RESET;
        else
        begin
            events_q <= (events_q & ~((reg_wr_in && reg_addr_in == aseu_pkg::ADDR_EVENTS)
                                      ? reg_wdata_in[4:0] : 5'h00))
                        | {!instr_shift_req && shift_req_in && sh.illegal,
                           exec_ok && to_pc,
                           instr_valid_in && unpred,
                           instr_valid_in && redirect,
                           instr_valid_in && op == aseu_pkg::OP_WIDE};
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            done_out            <= 1'b0;
            undef_out           <= 1'b0;
            sp_reg_redirect_out <= 1'b0;
            unpredictable_out   <= 1'b0;
            alu_pc_write_out    <= 1'b0;
            pc_target_out       <= 32'h0000_0000;
        end
        else
        begin
            done_out            <= instr_valid_in && (exec_ok || op == aseu_pkg::OP_HINT);
            undef_out           <= instr_valid_in && op == aseu_pkg::OP_WIDE;
            sp_reg_redirect_out <= instr_valid_in && redirect;
            unpredictable_out   <= instr_valid_in && unpred;
            alu_pc_write_out    <= exec_ok && to_pc;
            if (exec_ok && to_pc)
                pc_target_out <= sum_res;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            shift_valid_out   <= 1'b0;
            shift_result_out  <= 32'h0000_0000;
            shift_carry_out   <= 1'b0;
            shift_illegal_out <= 1'b0;
        end
        else
        begin
            shift_valid_out   <= !instr_shift_req && shift_req_in;
            shift_illegal_out <= !instr_shift_req && shift_req_in && sh.illegal;
            if (!instr_shift_req && shift_req_in)
            begin
                shift_result_out <= sh.result;
                shift_carry_out  <= sh.carry_out;
            end
        end
    end

    // Address generation never writes back the base register
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            agu_valid_out <= 1'b0;
            agu_addr_out  <= 32'h0000_0000;
        end
        else
        begin
            agu_valid_out <= agu_req_in;
            if (agu_req_in)
                agu_addr_out <= agu_sub_in ? agu_base_val - agu_offset
                                           : agu_base_val + agu_offset;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            reg_rdata_out <= 32'h0000_0000;
        else if (!reg_rd_in)
            reg_rdata_out <= 32'h0000_0000;
        else if (reg_addr_in <= aseu_pkg::ADDR_GPR_LAST)
            reg_rdata_out <= regs_q[reg_addr_in[3:0]];
        else if (reg_addr_in == aseu_pkg::ADDR_FLAGS)
            reg_rdata_out <= {flags_q, 28'h000_0000};
        else if (reg_addr_in == aseu_pkg::ADDR_EVENTS)
            reg_rdata_out <= {27'h000_0000, events_q};
        else
            reg_rdata_out <= 32'h0000_0000;
    end

    assign app_status_flags_out = flags_q;

    zero_shift_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (sh.amount == aseu_pkg::AMOUNT_NONE)
        |-> (sh.result == sh.value && sh.carry_out == sh.carry_in))
        else $error("zero shift altered value or carry");

    rrx_illegal_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (!instr_valid_in && shift_req_in && shift_kind_in == 3'h4 && shift_amt_in != 8'h01)
        |=> (shift_valid_out && shift_illegal_out))
        else $error("rotate extend with bad amount not flagged");

    ror_carry_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (sh.kind == aseu_pkg::SH_ROR && sh.amount != aseu_pkg::AMOUNT_NONE)
        |-> (sh.carry_out == sh.result[31]))
        else $error("rotate carry is not result bit 31");

    agu_addr_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (agu_req_in && !agu_use_index_in && agu_sub_in)
        |=> (agu_valid_out && agu_addr_out == $past(agu_base_val) - {24'h00_0000, $past(agu_imm_in)}))
        else $error("offset address wrong");

    wide_undef_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (instr_valid_in && instr_in[15:13] == 3'h7 && instr_in[12:11] != 2'h0)
        |=> (undef_out && !done_out && $stable(flags_q)))
        else $error("wide encoding not rejected");

    carry_add_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (instr_valid_in && op == aseu_pkg::OP_ADD_CARRY)
        |=> (regs_q[$past(d_idx)] == $past(opa) + $past(sh.value)
             + {31'h0, $past(flags_q[aseu_pkg::FLAG_C])}))
        else $error("add with carry result wrong");

    zero_flag_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (exec_ok && setflags)
        |=> (flags_q[aseu_pkg::FLAG_Z] == ($past(sum_res) == 32'h0)
             && flags_q[aseu_pkg::FLAG_N] == $past(sum_res[31])))
        else $error("N or Z flag wrong");

    pc_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (exec_ok && to_pc)
        |=> (alu_pc_write_out && pc_target_out == $past(sum_res) && $stable(flags_q)))
        else $error("counter write path misused");

    sp_redirect_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (instr_valid_in && redirect)
        |=> (sp_reg_redirect_out && !done_out) ##1 (!sp_reg_redirect_out || $past(instr_valid_in)))
        else $error("stack pointer form not redirected");

    sp_flags_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (instr_valid_in && (op == aseu_pkg::OP_SP_IMM_EIGHT_FIELD || op == aseu_pkg::OP_SP_IMM_SEVEN_FIELD))
        |=> ($stable(flags_q) && done_out))
        else $error("stack pointer add changed flags");

endmodule // aseu_exec_unit

/* verification/aseu_decode_model.sv */
// Decode stage model that hands instructions to the execute unit
`timescale 1ns/100ps
module aseu_decode_model (
    input  wire logic        clock_in,
    output logic             instr_valid_out,
    output logic [15:0]      instr_out
);
    initial instr_valid_out = 1'b0;
    initial instr_out = 16'h0000;
    // One instruction per call; the word is scrambled once valid drops
    task automatic issue(input logic [15:0] w);
        @(posedge clock_in);
        instr_valid_out <= 1'b1;
        instr_out       <= w;
        @(posedge clock_in);
        instr_valid_out <= 1'b0;
        instr_out       <= ~w;
    endtask
endmodule // aseu_decode_model

/* verification/tb_add_shift_execute_unit.sv */
// Self-checking bench of the add and shift execute unit
`timescale 1ns/100ps
module tb_add_shift_execute_unit;
    logic        clk, rst_n, sreq, areq, ause, asub, rwr, rrd, rd_seen, scar, sill, sv, av, iv;
    logic [15:0] ins;
    logic [2:0]  skind;
    logic [3:0]  flg, fo;
    logic [4:0]  raddr, pl, seen;
    logic [7:0]  samt, aimm;
    logic [31:0] wdata, rdata, sres, aaddr, a, b, s, v, pt;
    logic [33:0] exp_q[$];
    int          err_count = 0;
    int          n_compared = 0;
    aseu_decode_model m (.clock_in(clk), .instr_valid_out(iv), .instr_out(ins));
    aseu_exec_unit uut (
        .clock_in(clk), .rst_n_in(rst_n), .instr_valid_in(iv), .instr_in(ins),
        .shift_req_in(sreq), .shift_kind_in(skind), .shift_src_in(4'h1), .shift_amt_in(samt),
        .agu_req_in(areq), .agu_base_in(4'h1), .agu_index_in(4'h2), .agu_imm_in(aimm),
        .agu_use_index_in(ause), .agu_sub_in(asub), .reg_addr_in(raddr),
        .reg_wdata_in(wdata), .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rdata),
        .done_out(pl[4]), .undef_out(pl[3]), .sp_reg_redirect_out(pl[2]),
        .unpredictable_out(pl[1]), .alu_pc_write_out(pl[0]), .pc_target_out(pt),
        .shift_valid_out(sv),
        .shift_result_out(sres), .shift_carry_out(scar), .shift_illegal_out(sill),
        .agu_valid_out(av), .agu_addr_out(aaddr), .app_status_flags_out(fo)
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [3:0] nzcv(input logic [31:0] x, input logic [31:0] y,
                                        input logic ci);
        logic [32:0] t;
        t = {1'b0, x} + {1'b0, y} + {32'h0, ci};
        return {t[31], t[31:0] == 32'h0, t[32], (x[31] == y[31]) && (t[31] != x[31])};
    endfunction
    // Expected {illegal, carry, result} of a standalone shift
    function automatic logic [33:0] shx(input logic [2:0] k, input logic [7:0] n,
                                        input logic [31:0] x, input logic c);
        logic [63:0] t;
        if (n == 8'h00)
            return {k == 3'h4, c, x};
        case (k)
            3'h0: t = {32'h0, x} << n;
            3'h1: t = {x, 32'h0} >> n;
            3'h2: t = $signed({x, 32'h0}) >>> n;
            3'h3: t = {x, x} >> n;
            default: return (n == 8'h01) ? {1'b0, x[0], c, x[31:1]} : {1'b1, c, x};
        endcase
        if (k == 3'h0)
            return {1'b0, t[32], t[31:0]};
        return (k == 3'h3) ? {1'b0, t[31], t[31:0]} : {1'b0, t[31], t[63:32]};
    endfunction
    task automatic chk(input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        err_count += int'(g !== e);
        if (g !== e)
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
    endtask
    task automatic wr(input logic [4:0] ad, input logic [31:0] d);
        @(posedge clk);
        rwr   <= 1'b1;
        raddr <= ad;
        wdata <= d;
        @(posedge clk);
        rwr   <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] ad, input logic [31:0] e);
        @(posedge clk);
        rrd   <= 1'b1;
        raddr <= ad;
        exp_q.push_back({2'b00, e});
        @(posedge clk);
        rrd   <= 1'b0;
    endtask
    task automatic sh(input logic [2:0] k, input logic [7:0] n);
        @(posedge clk);
        sreq  <= 1'b1;
        skind <= k;
        samt  <= n;
        exp_q.push_back(shx(k, n, v, flg[1]));
        @(posedge clk);
        sreq  <= 1'b0;
    endtask
    task automatic ag(input logic u, input logic sb, input logic [7:0] im, input logic [31:0] e);
        @(posedge clk);
        areq <= 1'b1;
        ause <= u;
        asub <= sb;
        aimm <= im;
        exp_q.push_back({2'b00, e});
        @(posedge clk);
        areq <= 1'b0;
    endtask
    task automatic give_verdict();
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk)
        rd_seen <= rrd;
    // Every status pulse must show up at least once during the run
    always @(negedge clk)
        seen <= rst_n ? (seen | pl) : 5'h00;
    always @(negedge clk)
        if (rst_n && (rd_seen || sv || av) && exp_q.size() > 0)
            chk(exp_q.pop_front(), {sv & sill, sv & scar, sv ? sres : (av ? aaddr : rdata)});
    initial
    begin
        #20000;
        err_count++;
        give_verdict();
    end
    initial
    begin
        {rst_n, sreq, areq, ause, asub, rwr, rrd} = 7'h00;
        {skind, samt, aimm, raddr, wdata} = 56'h0;
        void'($urandom(88320));
        a = $urandom();
        b = $urandom();
        v = $urandom();
        s = $urandom();
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(5'h1F, 32'h0);
        wr(5'h01, a);
        wr(5'h02, b);
        m.issue({7'h0C, 3'h2, 3'h1, 3'h0});
        flg = nzcv(a, b, 1'b0);
        rd(5'h00, a + b);
        rd(5'h10, {flg, 28'h0});
        m.issue({10'h105, 3'h2, 3'h1});
        rd(5'h01, a + b + {31'h0, flg[1]});
        flg = nzcv(a, b, flg[1]);
        rd(5'h10, {flg, 28'h0});
        chk({30'h0, flg}, {30'h0, fo});
        wr(5'h01, 32'hFFFF_FFF9);
        m.issue({7'h0E, 3'h7, 3'h1, 3'h3});
        rd(5'h10, 32'h6000_0000);
        m.issue({5'h06, 3'h3, 8'hFF});
        rd(5'h03, 32'h0000_00FF);
        wr(5'h0D, s);
        m.issue({5'h15, 3'h4, 8'hFF});
        m.issue({9'h160, 7'h7F});
        rd(5'h04, s + 32'd1020);
        rd(5'h0D, s + 32'd508);
        rd(5'h10, 32'h0);
        m.issue({8'h44, 1'b1, 4'hD, 3'h5});
        m.issue({8'h44, 1'b0, 4'h2, 3'h5});
        m.issue({8'h44, 1'b1, 4'h2, 3'h7});
        m.issue({8'h44, 1'b1, 4'hF, 3'h7});
        rd(5'h05, b);
        rd(5'h0D, s + 32'd508);
        chk({2'b00, b}, {2'b00, pt});
        m.issue(16'hBF00);
        rd(5'h11, 32'h0000_000E);
        m.issue(16'hE800);
        wr(5'h01, v);
        flg = 4'h0;
        for (int k = 0; k < 5; k++)
            sh(3'(k), 8'h00);
        for (int k = 0; k < 4; k++)
            sh(3'(k), 8'(k * 9 + 1));
        sh(3'h4, 8'h01);
        sh(3'h4, 8'h02);
        ag(1'b0, 1'b0, 8'hFF, v + 32'd255);
        ag(1'b1, 1'b1, 8'h00, v - b);
        ag(1'b0, 1'b1, 8'h10, v - 32'h0000_0010);
        rd(5'h01, v);
        rd(5'h11, 32'h0000_001F);
        wr(5'h11, 32'h0000_001F);
        rd(5'h11, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk(34'h0_0000_001F, {29'h0, seen});
        err_count += exp_q.size();
        give_verdict();
    end
endmodule // tb_add_shift_execute_unit
